// [design/uef_top.sv]
// top: usb event flags, endpoint-0 control registers, line event detection and avalon slave
// What this block does
// [R1] ep0 transmit-done flag set after host ack
// [R2] ep0 IN answered NAK while transmit-done set
// [R3] software clears ep0 transmit-done, sets transmit enable
// [R4] ep0 receive-done set after data accepted, acked
// [R5] ep0 OUT answered NAK while receive-done set
// [R6] software clears receive-done, sets receive enable
// [R7] shared ep1/2 transmit-done set after host ack
// [R8] ep1/2 IN NAK while shared flag set
// [R9] end-of-packet flag set on valid line EOP
// [R10] wakeup flag set on activity while suspended
// [R11] ep0 toggle select picks DATA0 or DATA1
// [R12] software alone toggles the ep0 data toggle
// [R13] force-stall makes ep0 IN and OUT STALL
// [R14] SETUP token clears ep0 force-stall automatically
// [R15] ep0 IN NAK when disabled or done set
// [R16] software manages ep0 transmit enable
// [R17] ep0 OUT NAK when disabled or done set
// [R18] low nibble gives ep0 transmit byte count
// [R19] bus reset resets system when enabled
// [R20] flags 5..0 each interrupt only when their enable set; the suspend flag never interrupts
// [R21] bus-reset flag read-only, set on line reset
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/100ps
`default_nettype none
module uef_top
  import uef_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic [9:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic sie_token_valid_i,
  input wire logic [1:0] sie_token_kind_i,
  input wire logic [1:0] sie_token_ep_i,
  input wire logic sie_host_ack_i,
  input wire logic sie_data_good_i,
  output logic resp_valid_o,
  output logic [2:0] resp_code_o,
  output logic resp_data1_o,
  output logic [BYTE_COUNT_W-1:0] ep0_byte_count_o,
  output logic suspend_o,
  output logic irq_o,
  output logic system_reset_o
);
  function automatic logic reg_hit(input logic [9:0] addr, input logic [7:0] idx);
    reg_hit = (addr[9:2] == idx) && (addr[1:0] == 2'h0);
  endfunction : reg_hit

  uef_link_if lk ();

  uef_handshake u_handshake (
    .clock_i(clock_i),
    .rst_n_i(rst_n_i),
    .lk(lk)
  );

  logic [7:0] flags;
  logic [7:0] irq_en;
  logic [7:0] ep0_ctl;
  logic [7:0] ep12_ctl;
  logic [7:0] next_flags;
  logic [7:0] next_ep0_ctl;
  logic [7:0] next_ep12_ctl;
  logic ack_q;

  // line sampling: two stages before anything looks at the pins
  logic dp_meta;
  logic dm_meta;
  logic dp_s;
  logic dm_s;
  logic [SE0_CNT_W-1:0] se0_cnt;
  logic bus_reset_seen;
  logic prev_se0;

  // ---------------- avalon slave ----------------
  // one wait cycle per access: the answer lands at the second edge of the request
  wire bus_req = avs_read_i || avs_write_i;
  wire wr_fire = avs_write_i && ack_q && avs_byteenable_i[0];
  wire rd_fire = avs_read_i && ack_q;
  wire hit_flags = reg_hit(avs_address_i, FLAGS_IDX);
  wire hit_irq_en = reg_hit(avs_address_i, IRQ_EN_IDX);
  wire hit_ep0 = reg_hit(avs_address_i, EP0_CTL_IDX);
  wire hit_ep12 = reg_hit(avs_address_i, EP12_CTL_IDX);
  wire wr_flags = wr_fire && hit_flags;
  wire wr_irq_en = wr_fire && hit_irq_en;
  wire wr_ep0 = wr_fire && hit_ep0;
  wire wr_ep12 = wr_fire && hit_ep12;
  wire rd_flags = rd_fire && hit_flags;
  wire [7:0] wdata = avs_writedata_i[7:0];

  logic [7:0] read_mux;
  always_comb begin
    if (hit_flags) begin
      read_mux = flags;
    end else if (hit_irq_en) begin
      read_mux = irq_en;
    end else if (hit_ep0) begin
      read_mux = ep0_ctl;
    end else if (hit_ep12) begin
      read_mux = ep12_ctl;
    end else begin
      read_mux = 8'h00;
    end
  end

  assign avs_waitrequest_o = bus_req && !ack_q;

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ack_q <= 1'b0;
      avs_readdata_o <= 32'h00000000;
    end else begin
      ack_q <= bus_req && !ack_q;
      if (avs_read_i && !ack_q) begin
        avs_readdata_o <= {24'h000000, read_mux};
      end
    end
  end

  // ---------------- line event detection ----------------
  wire line_se0 = !dp_s && !dm_s;
  wire line_j = !dp_s && dm_s;
  wire se0_long = (se0_cnt >= SE0_CNT_W'(BUS_RESET_CYC));
  wire eop_seen = prev_se0 && line_j && (se0_cnt >= SE0_CNT_W'(EOP_SE0_CYC)) && !se0_long; // [R9]
  wire bus_reset_evt = se0_long && !bus_reset_seen; // [R21]
  wire activity = !line_j && flags[FLG_SUSPEND]; // [R10]

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      dp_meta <= 1'b0;
      dm_meta <= 1'b1;
      dp_s <= 1'b0;
      dm_s <= 1'b1;
    end else begin
      dp_meta <= dp_i;
      dm_meta <= dm_i;
      dp_s <= dp_meta;
      dm_s <= dm_meta;
    end
  end

  // se0 length is held after the line returns to J so the eop check can read it
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      se0_cnt <= '0;
      prev_se0 <= 1'b0;
    end else begin
      prev_se0 <= line_se0;
      if (line_se0 && !prev_se0) begin
        se0_cnt <= SE0_CNT_W'(1);
      end else if (line_se0 && !se0_long) begin
        se0_cnt <= se0_cnt + SE0_CNT_W'(1);
      end else if (!line_se0 && !prev_se0) begin
        se0_cnt <= '0;
      end
    end
  end

  // a bus-reset event when the se0 stretch gets long, and one more the second cycle after the line leaves se0
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      bus_reset_seen <= 1'b0;
    end else if (bus_reset_evt) begin
      bus_reset_seen <= 1'b1;
    end else if (!line_se0) begin
      bus_reset_seen <= 1'b0;
    end
  end

  // ---------------- link to handshake decider ----------------
  assign lk.tok_valid = sie_token_valid_i;
  assign lk.tok_kind = uef_tok_t'(sie_token_kind_i);
  assign lk.tok_ep = sie_token_ep_i;
  assign lk.host_ack = sie_host_ack_i;
  assign lk.data_good = sie_data_good_i;
  assign lk.ep0_force_stall = ep0_ctl[CTL0_STALL];
  assign lk.tx0_en = ep0_ctl[CTL0_TX_EN];
  assign lk.rx0_en = ep0_ctl[CTL0_RX_EN];
  assign lk.tx12_en = ep12_ctl[CTL12_TX_EN];
  assign lk.tx0_done = flags[FLG_EP0_TX];
  assign lk.rx0_done = flags[FLG_EP0_RX];
  assign lk.tx12_done = flags[FLG_EP12_TX];

  // ---------------- event flags ----------------
  // hardware sets beat a software write in the same cycle, so no event is lost except in a bus-reset cycle, which drops them
  logic [7:0] hw_set;
  always_comb begin
    hw_set = 8'h00;
    hw_set[FLG_EP0_TX] = lk.set_tx0; // [R1]
    hw_set[FLG_EP0_RX] = lk.set_rx0; // [R4]
    hw_set[FLG_EP12_TX] = lk.set_tx12; // [R7]
    hw_set[FLG_EOP] = eop_seen; // [R9]
    hw_set[FLG_WAKEUP] = activity; // [R10]
  end

  always_comb begin
    next_flags = flags;
    if (wr_flags) begin
      next_flags = (flags & ~FLAGS_RW_MASK) | (wdata & FLAGS_RW_MASK); // [R3] [R6] [R8] [R9] [R10]
    end
    // bus-reset flag: software cannot write it; a read of the register clears it
    if (rd_flags) begin
      next_flags[FLG_BUS_RESET] = 1'b0;
    end
    if (bus_reset_evt) begin
      next_flags = FLAGS_RST;
      next_flags[FLG_BUS_RESET] = 1'b1; // [R21]
    end else begin
      next_flags = next_flags | hw_set;
    end
    next_flags[6] = 1'b0;
  end

  // ---------------- endpoint control ----------------
  // a SETUP clearing stall is taken over a software write landing in the same cycle
  always_comb begin
    next_ep0_ctl = ep0_ctl;
    next_ep12_ctl = ep12_ctl;
    if (wr_ep0) begin
      next_ep0_ctl = wdata; // [R12] [R16]
    end
    if (wr_ep12) begin
      next_ep12_ctl = wdata & CTL12_MASK;
    end
    if (lk.clr_stall) begin
      next_ep0_ctl[CTL0_STALL] = 1'b0; // [R14]
    end
    if (bus_reset_evt) begin
      next_ep0_ctl = EP0_CTL_RST;
      next_ep12_ctl = EP12_CTL_RST;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      flags <= FLAGS_RST; // [R4] [R9] [R10]
    end else begin
      flags <= next_flags;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      ep0_ctl <= EP0_CTL_RST; // [R11] [R14] [R18]
      ep12_ctl <= EP12_CTL_RST;
    end else begin
      ep0_ctl <= next_ep0_ctl;
      ep12_ctl <= next_ep12_ctl;
    end
  end

  // the enable register survives a bus reset, so a system reset request stays armed
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_en <= IRQ_EN_RST;
    end else if (wr_irq_en) begin
      irq_en <= wdata;
    end
  end

  // ---------------- outputs toward the sie and the system ----------------
  // the interrupt is a plain level: bits 5..0 of flags line up with bits 5..0 of the enable register
  wire irq_next = |(flags[5:0] & irq_en[5:0]); // [R20]
  wire sys_reset_next = irq_en[IEN_SYS_RESET] && se0_long; // [R19]

  // resp_code_o falls back to none between answers; only resp_valid_o marks a handshake
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      resp_valid_o <= 1'b0;
      resp_code_o <= UEF_RESP_NONE;
      resp_data1_o <= 1'b0;
      ep0_byte_count_o <= '0;
    end else begin
      resp_valid_o <= lk.resp_valid;
      resp_code_o <= lk.resp;
      resp_data1_o <= ep0_ctl[CTL0_TOGGLE]; // [R11]
      ep0_byte_count_o <= ep0_ctl[BYTE_COUNT_W-1:0]; // [R18]
    end
  end

  // system reset follows the se0 stretch and drops a few cycles after the line returns to J
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      suspend_o <= 1'b0;
      irq_o <= 1'b0;
      system_reset_o <= 1'b0;
    end else begin
      suspend_o <= flags[FLG_SUSPEND];
      irq_o <= irq_next; // [R20]
      system_reset_o <= sys_reset_next; // [R19]
    end
  end
endmodule : uef_top
`default_nettype wire

// [design/uef_pkg.sv]
// package: register map, field positions, timing and shared types of the usb event block
package uef_pkg;
  // register indices; the byte address is four times the index
  localparam logic [7:0] FLAGS_IDX = 8'hE8;
  localparam logic [7:0] IRQ_EN_IDX = 8'hE9;
  localparam logic [7:0] EP0_CTL_IDX = 8'hEA;
  localparam logic [7:0] EP12_CTL_IDX = 8'hEB;
  // event flag register fields
  localparam int FLG_SUSPEND = 7;
  localparam int FLG_BUS_RESET = 5;
  localparam int FLG_EP0_TX = 4;
  localparam int FLG_EP0_RX = 3;
  localparam int FLG_EP12_TX = 2;
  localparam int FLG_EOP = 1;
  localparam int FLG_WAKEUP = 0;
  localparam logic [7:0] FLAGS_RW_MASK = 8'h9F;
  // endpoint-0 control register fields
  localparam int CTL0_TOGGLE = 7;
  localparam int CTL0_STALL = 6;
  localparam int CTL0_TX_EN = 5;
  localparam int CTL0_RX_EN = 4;
  localparam int BYTE_COUNT_W = 4;
  // interrupt enable and endpoint-1/2 control fields
  localparam int IEN_SYS_RESET = 6;
  localparam int CTL12_TX_EN = 5;
  localparam logic [7:0] CTL12_MASK = 8'h20;
  // reset values
  localparam logic [7:0] FLAGS_RST = 8'h00;
  localparam logic [7:0] IRQ_EN_RST = 8'h00;
  localparam logic [7:0] EP0_CTL_RST = 8'h00;
  localparam logic [7:0] EP12_CTL_RST = 8'h00;
  // line timing
  localparam int CLK_PERIOD_NS = 25;
  localparam int EOP_SE0_MIN_NS = 330;
  localparam int BUS_RESET_SE0_NS = 2500;
  localparam int EOP_SE0_CYC = (EOP_SE0_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUS_RESET_CYC = (BUS_RESET_SE0_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SE0_CNT_W = 8;

  typedef enum logic [1:0] {
    UEF_TOK_OUT = 2'h0,
    UEF_TOK_IN = 2'h1,
    UEF_TOK_SETUP = 2'h2,
    UEF_TOK_OTHER = 2'h3
  } uef_tok_t;

  typedef enum logic [2:0] {
    UEF_RESP_NAK = 3'h0,
    UEF_RESP_STALL = 3'h1,
    UEF_RESP_ACK = 3'h2,
    UEF_RESP_DATA = 3'h3,
    UEF_RESP_NONE = 3'h7
  } uef_resp_t;
endpackage : uef_pkg

// [design/uef_link_if.sv]
// interface: control state and events between the register file and the handshake decider
`timescale 1ns/100ps
`default_nettype none
interface uef_link_if;
  import uef_pkg::*;
  logic tok_valid;
  uef_tok_t tok_kind;
  logic [1:0] tok_ep;
  logic host_ack;
  logic data_good;
  logic ep0_force_stall;
  logic tx0_en;
  logic rx0_en;
  logic tx12_en;
  logic tx0_done;
  logic rx0_done;
  logic tx12_done;
  logic resp_valid;
  uef_resp_t resp;
  logic set_tx0;
  logic set_rx0;
  logic set_tx12;
  logic clr_stall;
  modport regs (output tok_valid, tok_kind, tok_ep, host_ack, data_good, ep0_force_stall, tx0_en, rx0_en, tx12_en,
    tx0_done, rx0_done, tx12_done, input resp_valid, resp, set_tx0, set_rx0, set_tx12, clr_stall);
  modport decide (input tok_valid, tok_kind, tok_ep, host_ack, data_good, ep0_force_stall, tx0_en, rx0_en, tx12_en,
    tx0_done, rx0_done, tx12_done, output resp_valid, resp, set_tx0, set_rx0, set_tx12, clr_stall);
endinterface : uef_link_if
`default_nettype wire

// [design/uef_handshake.sv]
// handshake decider: answers endpoint tokens and reports completed transfers
`timescale 1ns/100ps
`default_nettype none
module uef_handshake
  import uef_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  uef_link_if.decide lk
);
  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_WAIT_ACK0 = 4'b0010,
    ST_WAIT_ACK12 = 4'b0100,
    ST_WAIT_DATA0 = 4'b1000
  } uef_state_t;

  uef_state_t state;
  uef_state_t next_state;

  wire ep0 = (lk.tok_ep == 2'h0);
  wire ep12 = (lk.tok_ep == 2'h1) || (lk.tok_ep == 2'h2);
  wire in_tok = lk.tok_valid && (lk.tok_kind == UEF_TOK_IN);
  wire out_tok = lk.tok_valid && (lk.tok_kind == UEF_TOK_OUT);
  wire setup_tok = lk.tok_valid && (lk.tok_kind == UEF_TOK_SETUP);
  wire ep0_in_blocked = !lk.tx0_en || lk.tx0_done; // [R2] [R15]
  wire ep0_out_blocked = !lk.rx0_en || lk.rx0_done; // [R5] [R17]
  wire ep12_in_blocked = !lk.tx12_en || lk.tx12_done; // [R8]

  // a new token always wins over a wait, so a lost host ack cannot hang the decider
  always_comb begin
    next_state = state;
    lk.resp_valid = 1'b0;
    lk.resp = UEF_RESP_NONE;
    lk.set_tx0 = 1'b0;
    lk.set_rx0 = 1'b0;
    lk.set_tx12 = 1'b0;
    lk.clr_stall = 1'b0;
    if (setup_tok && ep0) begin
      lk.clr_stall = 1'b1; // [R14]
      next_state = ST_WAIT_DATA0;
    end else if ((in_tok || out_tok) && ep0 && lk.ep0_force_stall) begin
      lk.resp_valid = 1'b1;
      lk.resp = UEF_RESP_STALL; // [R13]
      next_state = ST_IDLE;
    end else if (in_tok && ep0) begin
      lk.resp_valid = 1'b1;
      lk.resp = ep0_in_blocked ? UEF_RESP_NAK : UEF_RESP_DATA; // [R2] [R15]
      next_state = ep0_in_blocked ? ST_IDLE : ST_WAIT_ACK0;
    end else if (out_tok && ep0) begin
      if (ep0_out_blocked) begin
        lk.resp_valid = 1'b1;
        lk.resp = UEF_RESP_NAK; // [R5] [R17]
      end
      next_state = ep0_out_blocked ? ST_IDLE : ST_WAIT_DATA0;
    end else if (in_tok && ep12) begin
      lk.resp_valid = 1'b1;
      lk.resp = ep12_in_blocked ? UEF_RESP_NAK : UEF_RESP_DATA; // [R8]
      next_state = ep12_in_blocked ? ST_IDLE : ST_WAIT_ACK12;
    end else if (lk.tok_valid) begin
      next_state = ST_IDLE;
    end else begin
      case (state)
        ST_WAIT_ACK0: begin
          if (lk.host_ack) begin
            lk.set_tx0 = 1'b1; // [R1]
            next_state = ST_IDLE;
          end
        end
        ST_WAIT_ACK12: begin
          if (lk.host_ack) begin
            lk.set_tx12 = 1'b1; // [R7]
            next_state = ST_IDLE;
          end
        end
        ST_WAIT_DATA0: begin
          if (lk.data_good) begin
            lk.resp_valid = 1'b1;
            lk.resp = UEF_RESP_ACK;
            lk.set_rx0 = 1'b1; // [R4]
            next_state = ST_IDLE;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
    end else begin
      state <= next_state;
    end
  end
endmodule : uef_handshake
`default_nettype wire

// [sim/uef_host_model.sv]
// partner model: usb host and line transceiver driving the sie-side ports
`timescale 1ns/100ps
`default_nettype none
module uef_host (
  input wire logic clock_i,
  output logic tok_v_o,
  output logic [1:0] tok_k_o,
  output logic [1:0] tok_ep_o,
  output logic ack_o,
  output logic good_o,
  output logic dp_o,
  output logic dm_o
);
  // low-speed idle is J: dp low, dm high
  initial begin
    {tok_v_o, tok_k_o, tok_ep_o, ack_o, good_o, dp_o} = 8'h00;
    dm_o = 1'b1;
  end

  task automatic token(input logic [1:0] k, input logic [1:0] e);
    @(posedge clock_i);
    tok_v_o <= 1'b1;
    tok_k_o <= k;
    tok_ep_o <= e;
    @(posedge clock_i);
    tok_v_o <= 1'b0;
    // released fields must not keep showing the last token
    tok_k_o <= ~k;
    tok_ep_o <= ~e;
  endtask : token

  task automatic pulse(input logic is_ack);
    @(posedge clock_i);
    if (is_ack) begin
      ack_o <= 1'b1;
    end else begin
      good_o <= 1'b1;
    end
    @(posedge clock_i);
    ack_o <= 1'b0;
    good_o <= 1'b0;
  endtask : pulse

  task automatic line(input logic p, input logic m, input int n);
    @(posedge clock_i);
    dp_o <= p;
    dm_o <= m;
    repeat (n) @(posedge clock_i);
  endtask : line
endmodule : uef_host
`default_nettype wire

// [sim/uef_assertions.sv]
// checker: port-level timing and answer properties of the usb event block
`timescale 1ns/100ps
`default_nettype none
module uef_chk
  import uef_pkg::*;
(
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic dp_i,
  input wire logic dm_i,
  input wire logic sie_token_valid_i,
  input wire logic [1:0] sie_token_kind_i,
  input wire logic [1:0] sie_token_ep_i,
  input wire logic sie_data_good_i,
  input wire logic resp_valid_o,
  input wire logic [2:0] resp_code_o,
  input wire logic [3:0] ep0_byte_count_o,
  input wire logic system_reset_o
);
  default clocking @(posedge clock_i); endclocking
  default disable iff (!rst_n_i);
  wire se0 = !dp_i && !dm_i;
  wire tok_in = sie_token_valid_i && sie_token_kind_i == UEF_TOK_IN;

  a_wait_one: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o)
    else $error("waitrequest longer than one cycle");
  a_upper_zero: assert property (avs_readdata_o[31:8] == 24'h000000)
    else $error("readdata upper bytes not zero");
  a_in_ep0: assert property (tok_in && sie_token_ep_i == 2'h0 |=> resp_valid_o)
    else $error("ep0 IN not answered");
  a_in_ep12: assert property (tok_in && sie_token_ep_i inside {2'h1, 2'h2} |=> resp_valid_o)
    else $error("ep1/2 IN not answered");
  a_setup_quiet: assert property (sie_token_valid_i && sie_token_kind_i == UEF_TOK_SETUP |=> !resp_valid_o)
    else $error("SETUP answered at once");
  a_other_quiet: assert property (sie_token_valid_i && sie_token_kind_i == UEF_TOK_OTHER |=> !resp_valid_o)
    else $error("unknown token answered");
  a_ack_cause: assert property (resp_valid_o && resp_code_o == UEF_RESP_ACK
    |-> $past(sie_data_good_i) || $past(sie_data_good_i, 2))
    else $error("ACK without good data");
  a_resp_cause: assert property (resp_valid_o && resp_code_o != UEF_RESP_ACK |-> $past(sie_token_valid_i))
    else $error("answer without token");
  a_reset_clean: assert property ($rose(rst_n_i)
    |-> ep0_byte_count_o == 4'h0 && resp_code_o == UEF_RESP_NONE && !resp_valid_o && !system_reset_o)
    else $error("outputs not cleared by reset");
  a_sysrst_cause: assert property ($rose(system_reset_o) |-> $past(se0, 10))
    else $error("system reset without long SE0");
endmodule : uef_chk

bind uef_top uef_chk u_chk (.clock_i, .rst_n_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .dp_i, .dm_i, .sie_token_valid_i, .sie_token_kind_i, .sie_token_ep_i, .sie_data_good_i, .resp_valid_o,
  .resp_code_o, .ep0_byte_count_o, .system_reset_o);
`default_nettype wire

// [sim/uef_top_tb.sv]
// testbench: register and token sequences for the usb event block
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin err_total++; \
  $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module uef_top_tb
  import uef_pkg::*;
;
  localparam logic [9:0] A_FLG = {FLAGS_IDX, 2'b00};
  localparam logic [9:0] A_IEN = {IRQ_EN_IDX, 2'b00};
  localparam logic [9:0] A_CTL = {EP0_CTL_IDX, 2'b00};
  localparam logic [9:0] A_E12 = {EP12_CTL_IDX, 2'b00};
  localparam logic [9:0] A_BAD = 10'h3B0;
  logic clock_i, rst_n_i, avs_read_i, avs_write_i, dp_i, dm_i;
  logic [9:0] avs_address_i;
  logic [31:0] avs_writedata_i, avs_readdata_o;
  logic [3:0] avs_byteenable_i, ep0_byte_count_o;
  logic avs_waitrequest_o, sie_token_valid_i, sie_host_ack_i, sie_data_good_i;
  logic [1:0] sie_token_kind_i, sie_token_ep_i;
  logic resp_valid_o, resp_data1_o, suspend_o, irq_o, system_reset_o;
  logic [2:0] resp_code_o;
  logic [7:0] rdata;
  int err_total = 0;
  int num_checks = 0;
  int cycles = 0;

  uef_top u_dut (.clock_i, .rst_n_i, .avs_address_i, .avs_read_i, .avs_write_i, .avs_writedata_i,
    .avs_byteenable_i, .avs_readdata_o, .avs_waitrequest_o, .dp_i, .dm_i, .sie_token_valid_i,
    .sie_token_kind_i, .sie_token_ep_i, .sie_host_ack_i, .sie_data_good_i, .resp_valid_o, .resp_code_o,
    .resp_data1_o, .ep0_byte_count_o, .suspend_o, .irq_o, .system_reset_o);
  uef_host u_host (.clock_i, .tok_v_o(sie_token_valid_i), .tok_k_o(sie_token_kind_i),
    .tok_ep_o(sie_token_ep_i), .ack_o(sie_host_ack_i), .good_o(sie_data_good_i), .dp_o(dp_i), .dm_o(dm_i));

  initial begin
    clock_i = 1'b0;
    forever #12.5 clock_i = ~clock_i;
  end

  task automatic final_report();
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : final_report

  // whole run needs well under a thousand cycles
  always @(posedge clock_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      err_total++;
      final_report();
    end
  end

  task automatic bus(input logic rd, input logic [9:0] a, input logic [7:0] d, input logic [3:0] be);
    @(posedge clock_i);
    avs_read_i <= rd;
    avs_write_i <= !rd;
    avs_address_i <= a;
    avs_writedata_i <= {24'h000000, d};
    avs_byteenable_i <= be;
    do @(posedge clock_i); while (avs_waitrequest_o !== 1'b0);
    rdata = avs_readdata_o[7:0];
    avs_read_i <= 1'b0;
    avs_write_i <= 1'b0;
    avs_address_i <= ~a;
    avs_writedata_i <= ~avs_writedata_i;
  endtask : bus

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    bus(1'b0, a, d, 4'h1);
  endtask : wr

  task automatic rd_chk(input logic [9:0] a, input logic [7:0] m, input logic [7:0] e, input string nm);
    bus(1'b1, a, 8'h00, 4'h0);
    `CHK(nm, e, rdata & m)
  endtask : rd_chk

  task automatic tk(input logic [1:0] k, input logic [1:0] e, input uef_resp_t r);
    u_host.token(k, e);
    #1;
    `CHK("resp_valid", r != UEF_RESP_NONE, resp_valid_o)
    if (r != UEF_RESP_NONE) `CHK("resp_code", r, resp_code_o)
  endtask : tk

  task automatic good();
    int n;
    n = 0;
    u_host.pulse(1'b0);
    #1;
    while (resp_valid_o !== 1'b1 && n < 3) begin
      @(posedge clock_i);
      #1;
      n++;
    end
    `CHK("ack", UEF_RESP_ACK, resp_code_o)
  endtask : good

  initial begin
    {rst_n_i, avs_read_i, avs_write_i, avs_address_i, avs_writedata_i, avs_byteenable_i} = 49'h0;
    repeat (20) @(posedge clock_i);
    rst_n_i <= 1'b1;
    rd_chk(A_FLG, 8'hFF, FLAGS_RST, "flags");
    rd_chk(A_CTL, 8'hFF, EP0_CTL_RST, "ep0_ctl");
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_NAK);
    wr(A_CTL, 8'hA5);
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_DATA);
    `CHK("data1", 1'b1, resp_data1_o)
    `CHK("count", 4'h5, ep0_byte_count_o)
    u_host.pulse(1'b1);
    rd_chk(A_FLG, 8'h10, 8'h10, "tx0_done");
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_NAK);
    rd_chk(A_CTL, 8'hFF, 8'hA5, "ep0_ctl");
    wr(A_FLG, 8'h00);
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_DATA);
    wr(A_CTL, 8'h23);
    bus(1'b0, A_CTL, 8'hFF, 4'h0);
    bus(1'b0, A_BAD, 8'hFF, 4'h1);
    rd_chk(A_BAD, 8'hFF, 8'h00, "unmapped");
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_DATA);
    `CHK("data1", 1'b0, resp_data1_o)
    `CHK("count", 4'h3, ep0_byte_count_o)
    // receive path
    tk(UEF_TOK_OUT, 2'h0, UEF_RESP_NAK);
    wr(A_CTL, 8'h10);
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_NAK);
    tk(UEF_TOK_OUT, 2'h0, UEF_RESP_NONE);
    good();
    rd_chk(A_FLG, 8'h08, 8'h08, "rx0_done");
    tk(UEF_TOK_OUT, 2'h0, UEF_RESP_NAK);
    wr(A_FLG, 8'h00);
    tk(UEF_TOK_OUT, 2'h0, UEF_RESP_NONE);
    // forced stall and its release by SETUP
    wr(A_CTL, 8'h70);
    tk(UEF_TOK_IN, 2'h0, UEF_RESP_STALL);
    tk(UEF_TOK_OUT, 2'h0, UEF_RESP_STALL);
    tk(UEF_TOK_SETUP, 2'h0, UEF_RESP_NONE);
    rd_chk(A_CTL, 8'h40, 8'h00, "ep0_force_stall");
    good();
    // shared endpoint-1/2 transmit
    wr(A_E12, 8'h20);
    tk(UEF_TOK_IN, 2'h1, UEF_RESP_DATA);
    u_host.pulse(1'b1);
    rd_chk(A_FLG, 8'h04, 8'h04, "tx12_done");
    tk(UEF_TOK_IN, 2'h2, UEF_RESP_NAK);
    tk(UEF_TOK_OUT, 2'h1, UEF_RESP_NONE);
    tk(UEF_TOK_OTHER, 2'h0, UEF_RESP_NONE);
    tk(UEF_TOK_IN, 2'h3, UEF_RESP_NONE);
    wr(A_FLG, 8'h00);
    tk(UEF_TOK_IN, 2'h2, UEF_RESP_DATA);
    // line events
    u_host.line(1'b0, 1'b0, 20);
    u_host.line(1'b0, 1'b1, 6);
    rd_chk(A_FLG, 8'h02, 8'h02, "eop");
    wr(A_FLG, 8'h80);
    rd_chk(A_FLG, 8'hFF, 8'h80, "flags");
    `CHK("suspend", 1'b1, suspend_o)
    u_host.line(1'b1, 1'b0, 4);
    u_host.line(1'b0, 1'b1, 4);
    rd_chk(A_FLG, 8'h01, 8'h01, "wakeup");
    `CHK("irq", 1'b0, irq_o)
    wr(A_IEN, 8'h01);
    rd_chk(A_IEN, 8'hFF, 8'h01, "irq_en");
    `CHK("irq", 1'b1, irq_o)
    wr(A_FLG, 8'h00);
    rd_chk(A_FLG, 8'hFF, 8'h00, "flags");
    `CHK("irq", 1'b0, irq_o)
    // bus reset with system reset enabled
    wr(A_IEN, 8'h40);
    u_host.line(1'b0, 1'b0, 120);
    `CHK("sys_reset", 1'b1, system_reset_o)
    u_host.line(1'b0, 1'b1, 6);
    `CHK("sys_reset", 1'b0, system_reset_o)
    rd_chk(A_FLG, 8'h20, 8'h20, "bus_reset");
    rd_chk(A_FLG, 8'h20, 8'h00, "bus_reset");
    rd_chk(A_CTL, 8'hFF, 8'h00, "ep0_ctl");
    wr(A_FLG, 8'h20);
    rd_chk(A_FLG, 8'h20, 8'h00, "bus_reset");
    final_report();
  end
endmodule : uef_top_tb
`default_nettype wire
